// *** fdi_defines.svh ***
// Register indices, field masks, reset values and fixed codes for the
// fast-DMA completion, interrupt and trigger-select logic.
// Assumes byte address = four times the register index on the bus.
`ifndef FDI_DEFINES_SVH
`define FDI_DEFINES_SVH
`define FDI_IDX_PRIO01 32'h0004_0263
`define FDI_IDX_PRIO23 32'h0004_0264
`define FDI_IDX_IRQEN 32'h0004_0271
`define FDI_IDX_FLAGS 32'h0004_0281
`define FDI_IDX_SREQ 32'h0004_0290
`define FDI_IDX_SEN 32'h0004_0294
`define FDI_IDX_TRG01 32'h0004_0298
`define FDI_IDX_TRG23 32'h0004_0299
`define FDI_IDX_TTB 32'h0004_8134
`define FDI_MSK_PRIO 8'h77
`define FDI_MSK_IRQEN 8'h1F
`define FDI_MSK_FLAGS 8'h1F
`define FDI_MSK_SMART 8'h30
`define FDI_BIT_SMART_DONE 4
`define FDI_BIT_SMART_CH0 4
`define FDI_RST_BYTE 8'h00
`define FDI_RST_TTB 32'h00C0_0000
`define FDI_VEC_OFS 32'h0000_0058
`define FDI_SMART_CH0 8'h05
`define FDI_SMART_CH1 8'h06
`define FDI_TRG_FSIO_RX 4'hD
`define FDI_TRG_FSIO_TX 4'hE
`endif

// *** fdi_pkg.sv ***
// Carrier types for the fast-DMA completion and interrupt logic.
// Assumes nothing beyond a SystemVerilog compiler.
package fdi_pkg;
   typedef struct packed {
      logic hsel;
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
      logic [31:0] hwdata;
   } fdi_ahb_req_t;
   typedef struct packed {
      logic [3:0] tc_zero;
      logic [3:0] done_irq_permit;
      logic [3:0] single_addr;
      logic [3:0] half_word;
      logic [3:0] io_byte;
   } fdi_chan_in_t;
   typedef struct packed {
      logic [3:0] sw;
      logic [3:0] pin;
      logic [3:0] port_a;
      logic [3:0] port_b;
      logic [3:0] t8_uf;
      logic [15:0] t16;
      logic [1:0] sio_rx;
      logic [1:0] sio_tx;
      logic adc_done;
      logic fsio_rx;
      logic fsio_tx;
   } fdi_trig_in_t;
   typedef struct packed {
      logic req;
      logic [1:0] chan;
      logic [2:0] level;
      logic [31:0] vector;
   } fdi_irq_t;
   typedef struct packed {
      logic [1:0] start;
      logic [7:0] num0;
      logic [7:0] num1;
   } fdi_smart_t;
endpackage

// *** fdi_ctrl.sv ***
// Completion, interrupt and trigger-select logic of a four-channel fast DMA.
// Assumes one AHB-Lite master, the transfer engine reporting counter-zero
// pulses, and same-clock peripheral events except pins and ports.
`timescale 1ns/10ps
`include "fdi_defines.svh"
module fdi_ctrl import fdi_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire fdi_ahb_req_t ahb_in,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire fdi_chan_in_t chan_in,
   input wire fdi_trig_in_t trig_in,
   input wire logic [1:0] smart_done,
   output logic [3:0] transfer_done_n,
   output logic [3:0] ch_trigger,
   output logic [3:0] two_bus_ops,
   output fdi_irq_t irq_out,
   output fdi_smart_t smart_out
);
   logic [7:0] prio01_reg, prio23_reg, irq_en_reg, flags_reg;
   logic [7:0] sreq_reg, sen_reg, trg01_reg, trg23_reg;
   logic [31:0] ttb_reg, addr_reg, rd_val;
   logic wr_pend_reg, rd_pend_reg;
   logic [1:0] busy_reg;
   logic [11:0] s1_reg, s2_reg, s3_reg, stab_reg, prev_reg;
   logic [3:0] done_set, pend_vec, trig_next;
   logic [1:0] smart_go;
   logic [2:0] lvl [4];
   logic [1:0] win_ch;
   logic win_req;
   function automatic logic fdi_hit(input logic [31:0] a,
                                    input logic [31:0] idx);
      fdi_hit = (a == {idx[29:0], 2'b00});
   endfunction
   // Picks one event by its 4-bit select code
   function automatic logic fdi_pick(input logic [3:0] code,
                                     input logic [15:0] ev);
      fdi_pick = ev[code];
   endfunction
   wire accept = ahb_in.hsel & hready & ahb_in.htrans[1];
   wire [7:0] wb = ahb_in.hwdata[7:0];
   wire wr_flags = wr_pend_reg & fdi_hit(addr_reg, `FDI_IDX_FLAGS);
   // Bus slave: writes take no wait, reads take one so data reflect writes
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= accept & ahb_in.hwrite;
         rd_pend_reg <= accept & ~ahb_in.hwrite;
         if (accept) begin
            addr_reg <= ahb_in.haddr;
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         hrdata <= 32'h0000_0000;
      end else begin
         hresp <= 1'b0;
         hreadyout <= ~(accept & ~ahb_in.hwrite);
         if (rd_pend_reg) begin
            hrdata <= rd_val;
         end
      end
   end
   always_comb begin
      rd_val = 32'h0000_0000;
      if (fdi_hit(addr_reg, `FDI_IDX_PRIO01)) begin
         rd_val[7:0] = prio01_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_PRIO23)) begin
         rd_val[7:0] = prio23_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_IRQEN)) begin
         rd_val[7:0] = irq_en_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_FLAGS)) begin
         rd_val[7:0] = flags_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_SREQ)) begin
         rd_val[7:0] = sreq_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_SEN)) begin
         rd_val[7:0] = sen_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_TRG01)) begin
         rd_val[7:0] = trg01_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_TRG23)) begin
         rd_val[7:0] = trg23_reg;
      end else if (fdi_hit(addr_reg, `FDI_IDX_TTB)) begin
         rd_val = ttb_reg;
      end
   end
   // Configuration registers; masks keep reserved bits at zero
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prio01_reg <= `FDI_RST_BYTE;
         prio23_reg <= `FDI_RST_BYTE;
         irq_en_reg <= `FDI_RST_BYTE;
         sreq_reg <= `FDI_RST_BYTE;
         sen_reg <= `FDI_RST_BYTE;
         trg01_reg <= `FDI_RST_BYTE;
         trg23_reg <= `FDI_RST_BYTE;
         ttb_reg <= `FDI_RST_TTB;
      end else if (wr_pend_reg) begin
         if (fdi_hit(addr_reg, `FDI_IDX_PRIO01)) begin
            prio01_reg <= wb & `FDI_MSK_PRIO;
         end
         if (fdi_hit(addr_reg, `FDI_IDX_PRIO23)) begin
            prio23_reg <= wb & `FDI_MSK_PRIO;
         end
         if (fdi_hit(addr_reg, `FDI_IDX_IRQEN)) begin
            irq_en_reg <= wb & `FDI_MSK_IRQEN;
         end
         if (fdi_hit(addr_reg, `FDI_IDX_SREQ)) begin
            sreq_reg <= wb & `FDI_MSK_SMART;
         end
         if (fdi_hit(addr_reg, `FDI_IDX_SEN)) begin
            sen_reg <= wb & `FDI_MSK_SMART;
         end
         if (fdi_hit(addr_reg, `FDI_IDX_TRG01)) begin
            trg01_reg <= wb;
         end
         if (fdi_hit(addr_reg, `FDI_IDX_TRG23)) begin
            trg23_reg <= wb;
         end
         if (fdi_hit(addr_reg, `FDI_IDX_TTB)) begin
            ttb_reg <= ahb_in.hwdata;
         end
      end
   end
   // Completion factor: set needs the permit bit, not the enable bit
   assign done_set = chan_in.tc_zero & chan_in.done_irq_permit;
   wire smart_any = |smart_done;
   // Software clears with ones; a set in the same cycle wins
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         flags_reg <= `FDI_RST_BYTE;
      end else begin
         flags_reg <= ((flags_reg & ~(wr_flags ? wb : 8'h00))
                      | {3'b000, smart_any, done_set})
                      & `FDI_MSK_FLAGS;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         transfer_done_n <= 4'hF;
         two_bus_ops <= 4'h0;
      end else begin
         transfer_done_n <= ~chan_in.tc_zero;
         two_bus_ops <= chan_in.single_addr & chan_in.half_word
                        & chan_in.io_byte;
      end
   end
   // Only channels 0 and 1 can hand their factor to smart DMA
   assign smart_go = done_set[1:0]
      & sreq_reg[`FDI_BIT_SMART_CH0+1:`FDI_BIT_SMART_CH0]
      & sen_reg[`FDI_BIT_SMART_CH0+1:`FDI_BIT_SMART_CH0];
   // Busy masks the CPU request until the smart transfer ends
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_reg <= 2'b00;
         smart_out <= '0;
      end else begin
         busy_reg <= (busy_reg & ~smart_done) | smart_go;
         smart_out.start <= smart_go;
         smart_out.num0 <= `FDI_SMART_CH0;
         smart_out.num1 <= `FDI_SMART_CH1;
      end
   end
   assign lvl[0] = prio01_reg[2:0];
   assign lvl[1] = prio01_reg[6:4];
   assign lvl[2] = prio23_reg[2:0];
   assign lvl[3] = prio23_reg[6:4];
   // Level request, dropped by the enable bit or a cleared flag
   assign pend_vec = flags_reg[3:0] & irq_en_reg[3:0]
                     & {2'b11, ~busy_reg};
   // Highest level wins; on a tie the lower channel keeps it
   always_comb begin
      win_req = 1'b0;
      win_ch = 2'd0;
      for (int i = 0; i < 4; i++) begin
         if (pend_vec[i] && (!win_req || lvl[i] > lvl[win_ch])) begin
            win_req = 1'b1;
            win_ch = i[1:0];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         irq_out <= '0;
      end else begin
         irq_out.req <= win_req;
         irq_out.chan <= win_ch;
         irq_out.level <= lvl[win_ch];
         irq_out.vector <= ttb_reg + `FDI_VEC_OFS
                           + {28'h000_0000, win_ch, 2'b00};
      end
   end
   // Pins and ports: three stages, a change counts when stages 2 and 3 agree
   wire [11:0] raw = {trig_in.port_b, trig_in.port_a, trig_in.pin};
   wire [11:0] agree = ~(s2_reg ^ s3_reg);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_reg <= 12'h000;
         s2_reg <= 12'h000;
         s3_reg <= 12'h000;
         stab_reg <= 12'h000;
         prev_reg <= 12'h000;
      end else begin
         s1_reg <= raw;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         stab_reg <= (s3_reg & agree) | (stab_reg & ~agree);
         prev_reg <= stab_reg;
      end
   end
   // Sources are sampled only; no clear is ever sent back to them
   for (genvar c = 0; c < 4; c++) begin : g_trig
      logic [15:0] ev;
      wire [3:0] code = (c < 2) ? trg01_reg[4*(c%2)+:4]
                                : trg23_reg[4*(c%2)+:4];
      always_comb begin
         ev = 16'h0000;
         ev[0] = trig_in.sw[c];
         ev[1] = prev_reg[c] & ~stab_reg[c];
         ev[2] = ~prev_reg[c] & stab_reg[c];
         ev[3] = stab_reg[4+c];
         ev[4] = stab_reg[8+c];
         ev[5] = trig_in.t8_uf[c];
         ev[9:6] = trig_in.t16[4*c+:4];
         ev[10] = trig_in.sio_rx[c%2];
         ev[11] = trig_in.sio_tx[c%2];
         ev[12] = trig_in.adc_done;
         // Even channels leave D and E reserved
         ev[`FDI_TRG_FSIO_RX] = (c % 2 == 1) & trig_in.fsio_rx;
         ev[`FDI_TRG_FSIO_TX] = (c % 2 == 1) & trig_in.fsio_tx;
      end
      assign trig_next[c] = fdi_pick(code, ev);
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ch_trigger <= 4'h0;
      end else begin
         ch_trigger <= trig_next;
      end
   end
   property p_done_pin;
      @(posedge clk) disable iff (!rst_n)
      chan_in.tc_zero[1] |=> !transfer_done_n[1] && (flags_reg[1]
         || !$past(chan_in.done_irq_permit[1]));
   endproperty
   a_done_pin: assert property (p_done_pin)
      else $error("done pin or flag missing at counter zero");
   property p_flag_free;
      @(posedge clk) disable iff (!rst_n)
      chan_in.tc_zero[3] && chan_in.done_irq_permit[3] && !irq_en_reg[3]
      |=> flags_reg[3];
   endproperty
   a_flag_free: assert property (p_flag_free)
      else $error("flag not set with enable low");
   property p_no_permit;
      @(posedge clk) disable iff (!rst_n)
      !flags_reg[3] && !chan_in.done_irq_permit[3] |=> !flags_reg[3];
   endproperty
   a_no_permit: assert property (p_no_permit)
      else $error("flag set without permit");
   property p_irq_gate;
      @(posedge clk) disable iff (!rst_n)
      irq_out.req && irq_out.chan == 2'd2 |-> $past(irq_en_reg[2]);
   endproperty
   a_irq_gate: assert property (p_irq_gate)
      else $error("request with enable low");
   property p_prio;
      @(posedge clk) disable iff (!rst_n)
      pend_vec[1] && pend_vec[0] && lvl[1] > lvl[0]
      |=> irq_out.req && irq_out.chan != 2'd0;
   endproperty
   a_prio: assert property (p_prio)
      else $error("lower level forwarded");
   property p_smart_noirq;
      @(posedge clk) disable iff (!rst_n)
      smart_go[0] |=> smart_out.start[0] && smart_out.num0 == `FDI_SMART_CH0
                   ##1 !(irq_out.req && irq_out.chan == 2'd0);
   endproperty
   a_smart_noirq: assert property (p_smart_noirq)
      else $error("smart start wrong or request raised");
   property p_smart_ch1;
      @(posedge clk) disable iff (!rst_n)
      smart_go[1] |=> smart_out.start[1] && smart_out.num1 == `FDI_SMART_CH1;
   endproperty
   a_smart_ch1: assert property (p_smart_ch1)
      else $error("smart channel number wrong");
   property p_smart_after;
      @(posedge clk) disable iff (!rst_n)
      $fell(busy_reg[0]) && pend_vec == 4'b0001
      |=> irq_out.req && irq_out.chan == 2'd0;
   endproperty
   a_smart_after: assert property (p_smart_after)
      else $error("no request after smart transfer");
   property p_vector;
      @(posedge clk) disable iff (!rst_n)
      irq_out.req |-> irq_out.vector == $past(ttb_reg) + `FDI_VEC_OFS
                      + {28'h000_0000, irq_out.chan, 2'b00};
   endproperty
   a_vector: assert property (p_vector)
      else $error("vector address wrong");
   property p_two_ops;
      @(posedge clk) disable iff (!rst_n)
      chan_in.single_addr[3] && chan_in.half_word[3] && !chan_in.io_byte[3]
      |=> !two_bus_ops[3];
   endproperty
   a_two_ops: assert property (p_two_ops)
      else $error("two operations for word-wide device");
endmodule

// *** fdi_far_model.sv ***
// Far-side model: CPU interrupt acceptance and the smart DMA engine that
// answers the latest start pulse with a done pulse after a programmable delay.
// Assumes the same clock and synchronous active-low reset as the block.
`timescale 1ns/10ps
module fdi_far_model import fdi_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire fdi_irq_t irq,
   input wire fdi_smart_t smart,
   input wire logic cpu_irq_enable,
   input wire logic [2:0] cpu_irq_level,
   input wire logic [3:0] done_delay,
   output logic [1:0] smart_done,
   output logic irq_taken
);
   logic [1:0] busy_reg;
   logic [3:0] wait_reg;
   // One transfer at a time; a new start while busy restarts the wait
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy_reg <= 2'b00;
         wait_reg <= 4'h0;
         smart_done <= 2'b00;
      end else begin
         smart_done <= 2'b00;
         if (smart.start != 2'b00) begin
            busy_reg <= smart.start;
            wait_reg <= done_delay;
         end else if (busy_reg != 2'b00) begin
            if (wait_reg == 4'h0) begin
               smart_done <= busy_reg;
               busy_reg <= 2'b00;
            end else begin
               wait_reg <= wait_reg - 4'h1;
            end
         end
      end
   end
   // Taken only with enable set and a strictly lower current level
   assign irq_taken = irq.req & cpu_irq_enable & (cpu_irq_level < irq.level);
endmodule

// *** tb_top.sv ***
// Self-checking bench for the fast-DMA completion and interrupt logic.
// Assumes the far-side model file and the design's package and header.
`timescale 1ns/10ps
`include "fdi_defines.svh"
module tb_top import fdi_pkg::*; ;
   localparam logic [31:0] adr_prio01 = `FDI_IDX_PRIO01 * 4;
   localparam logic [31:0] adr_prio23 = `FDI_IDX_PRIO23 * 4;
   localparam logic [31:0] adr_irqen = `FDI_IDX_IRQEN * 4;
   localparam logic [31:0] adr_flags = `FDI_IDX_FLAGS * 4;
   localparam logic [31:0] adr_sreq = `FDI_IDX_SREQ * 4;
   localparam logic [31:0] adr_sen = `FDI_IDX_SEN * 4;
   localparam logic [31:0] adr_trg01 = `FDI_IDX_TRG01 * 4;
   localparam logic [31:0] adr_trg23 = `FDI_IDX_TRG23 * 4;
   localparam logic [31:0] adr_ttb = `FDI_IDX_TTB * 4;
   logic clk = 1'b0;
   logic rst_n;
   fdi_ahb_req_t bus;
   logic hreadyout, hresp, taken, cpu_ie, got;
   logic [31:0] hrdata, rd;
   fdi_chan_in_t chan;
   fdi_trig_in_t trig;
   logic [1:0] smart_done, seen_start;
   logic [3:0] done_n, ch_trig, two_ops, delay;
   logic [2:0] cpu_il;
   fdi_irq_t irq;
   fdi_smart_t smart;
   int fails = 0;
   int compares = 0;
   always #5 clk = ~clk;
   fdi_ctrl uut (.clk(clk), .rst_n(rst_n), .ahb_in(bus), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chan_in(chan),
      .trig_in(trig), .smart_done(smart_done), .transfer_done_n(done_n),
      .ch_trigger(ch_trig), .two_bus_ops(two_ops), .irq_out(irq),
      .smart_out(smart));
   fdi_far_model far (.clk(clk), .rst_n(rst_n), .irq(irq), .smart(smart),
      .cpu_irq_enable(cpu_ie), .cpu_irq_level(cpu_il), .done_delay(delay),
      .smart_done(smart_done), .irq_taken(taken));
   task complete_run;
      if (fails == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // Hready is sampled at the edge itself, before the slave updates it
   task hold_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin
         fails++;
         $display("unexpected at %0t: bus wait ran out", $time);
         complete_run;
      end
   endtask
   task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
      @(posedge clk);
      bus.hsel <= 1'b1;
      bus.haddr <= a;
      bus.htrans <= 2'b10;
      bus.hwrite <= w;
      bus.hsize <= 3'b010;
      hold_ready;
      bus.hsel <= 1'b0;
      bus.htrans <= 2'b00;
      bus.hwdata <= d;
      hold_ready;
      rd = hrdata;
      check(32'(hresp), 32'h0000_0000);
   endtask
   task rdchk(input logic [31:0] a, input logic [31:0] exp);
      xfer(1'b0, a, 32'h0000_0000);
      check(rd, exp);
   endtask
   task pulse(input logic [3:0] m);
      @(posedge clk);
      chan.tc_zero <= m;
      @(posedge clk);
      chan.tc_zero <= 4'h0;
      #1;
      check(32'(done_n), {28'h0, ~m});
      seen_start = smart.start;
      @(posedge clk);
      #1;
      check(32'(done_n), 32'h0000_000F);
   endtask
   task settle;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task wait_req(input logic want);
      int n;
      got = 1'b0;
      for (n = 0; n < 20 && got !== 1'b1; n++) begin
         @(posedge clk);
         #1;
         got = irq.req;
      end
      if (want && got !== 1'b1) begin
         fails++;
         $display("unexpected at %0t: request wait ran out", $time);
         complete_run;
      end
   endtask
   task t_regs;
      rdchk(adr_irqen, 32'h0000_0000);
      rdchk(adr_sreq, 32'h0000_0000);
      rdchk(adr_sen, 32'h0000_0000);
      rdchk(adr_trg01, 32'h0000_0000);
      rdchk(adr_trg23, 32'h0000_0000);
      rdchk(adr_ttb, `FDI_RST_TTB);
      xfer(1'b1, adr_prio01, 32'hFFFF_FFFF);
      rdchk(adr_prio01, 32'h0000_0077);
      xfer(1'b1, adr_irqen, 32'hFFFF_FFFF);
      rdchk(adr_irqen, 32'h0000_001F);
      xfer(1'b1, adr_sen, 32'hFFFF_FFFF);
      rdchk(adr_sen, 32'h0000_0030);
      xfer(1'b1, 32'h0000_0000, 32'h1234_5678);
      rdchk(32'h0000_0000, 32'h0000_0000);
      xfer(1'b1, adr_irqen, 32'h0000_0000);
      xfer(1'b1, adr_sen, 32'h0000_0000);
   endtask
   task t_done;
      xfer(1'b1, adr_prio23, 32'h0000_0007);
      xfer(1'b1, adr_irqen, 32'h0000_0004);
      pulse(4'h4);
      check(32'(irq.req), 32'h0000_0001);
      check(32'(irq.chan), 32'h0000_0002);
      check(32'(irq.level), 32'h0000_0007);
      check(irq.vector, 32'h00C0_0060);
      pulse(4'h8);
      rdchk(adr_flags, 32'h0000_000C);
      xfer(1'b1, adr_flags, 32'h0000_0004);
      settle;
      check(32'(irq.req), 32'h0000_0000);
      xfer(1'b1, adr_flags, 32'h0000_001F);
      @(posedge clk);
      chan.done_irq_permit <= 4'h0;
      pulse(4'h8);
      rdchk(adr_flags, 32'h0000_0000);
      chan.done_irq_permit <= 4'hF;
   endtask
   task t_arb;
      xfer(1'b1, adr_prio01, 32'h0000_0052);
      xfer(1'b1, adr_irqen, 32'h0000_0003);
      pulse(4'h3);
      check(32'(irq.chan), 32'h0000_0001);
      check(irq.vector, 32'h00C0_005C);
      @(posedge clk);
      cpu_ie <= 1'b1;
      cpu_il <= 3'h4;
      #1;
      check(32'(taken), 32'h0000_0001);
      @(posedge clk);
      cpu_il <= 3'h5;
      #1;
      check(32'(taken), 32'h0000_0000);
      xfer(1'b1, adr_flags, 32'h0000_0002);
      settle;
      check(irq.vector, 32'h00C0_0058);
      xfer(1'b1, adr_prio01, 32'h0000_0033);
      pulse(4'h2);
      check(32'(irq.chan), 32'h0000_0000);
      xfer(1'b1, adr_ttb, 32'h0010_0000);
      settle;
      check(irq.vector, 32'h0010_0058);
      xfer(1'b1, adr_ttb, `FDI_RST_TTB);
      xfer(1'b1, adr_flags, 32'h0000_001F);
      xfer(1'b1, adr_irqen, 32'h0000_0000);
   endtask
   // Channel 0 answers promptly with its interrupt on; channel 1 slowly
   // with the interrupt left off, so only the smart transfer happens
   task t_smart(input int c, input logic en);
      @(posedge clk);
      delay <= (c == 1) ? 4'h8 : 4'h1;
      xfer(1'b1, adr_prio01, 32'h0000_0044);
      xfer(1'b1, adr_irqen, en ? (32'h0000_0001 << c) : 32'h0000_0000);
      xfer(1'b1, adr_sreq, 32'h0000_0010 << c);
      xfer(1'b1, adr_sen, 32'h0000_0010 << c);
      pulse(4'h1 << c);
      check(32'(seen_start), 32'h0000_0001 << c);
      check(32'(smart.start), 32'h0000_0000);
      check(32'(irq.req), 32'h0000_0000);
      check(32'(smart.num0), 32'h0000_0005);
      check(32'(smart.num1), 32'h0000_0006);
      wait_req(en);
      check(32'(got), 32'(en));
      if (en)
         check(32'(irq.chan), 32'(c));
      rdchk(adr_flags, 32'h0000_0010 | (32'h0000_0001 << c));
      xfer(1'b1, adr_flags, 32'h0000_001F);
      xfer(1'b1, adr_sreq, 32'h0000_0000);
      xfer(1'b1, adr_sen, 32'h0000_0000);
      xfer(1'b1, adr_irqen, 32'h0000_0000);
   endtask
   task t_trig;
      fdi_trig_in_t ev;
      logic [3:0] code;
      logic hit;
      logic exp_hit;
      for (int ch = 0; ch < 4; ch++) begin
         for (int k = 0; k < 16; k++) begin
            code = 4'(k);
            xfer(1'b1, (ch < 2) ? adr_trg01 : adr_trg23,
               (ch % 2 == 1) ? {24'h0, code, 4'hF} : {24'h0, 4'hF, code});
            ev = '0;
            case (k)
               0: ev.sw[ch] = 1'b1;
               1, 2: ev.pin[ch] = 1'b1;
               3: ev.port_a[ch] = 1'b1;
               4: ev.port_b[ch] = 1'b1;
               5: ev.t8_uf[ch] = 1'b1;
               6, 7, 8, 9: ev.t16[4 * ch + k - 6] = 1'b1;
               10: ev.sio_rx[ch % 2] = 1'b1;
               11: ev.sio_tx[ch % 2] = 1'b1;
               12: ev.adc_done = 1'b1;
               13: ev.fsio_rx = 1'b1;
               14: ev.fsio_tx = 1'b1;
               default: ev = '0;
            endcase
            hit = 1'b0;
            // Hold then drop the event so both pin edges are seen
            @(posedge clk);
            trig <= ev;
            repeat (8) begin
               @(posedge clk);
               #1;
               if (ch_trig[ch] === 1'b1) hit = 1'b1;
            end
            @(posedge clk);
            trig <= '0;
            repeat (8) begin
               @(posedge clk);
               #1;
               if (ch_trig[ch] === 1'b1) hit = 1'b1;
            end
            exp_hit = !(k == 15 || (k > 12 && ch % 2 == 0));
            check(32'(hit), 32'(exp_hit));
         end
      end
      xfer(1'b1, adr_trg01, 32'h0000_0000);
      xfer(1'b1, adr_trg23, 32'h0000_0000);
   endtask
   task t_ops;
      for (int k = 0; k < 8; k++) begin
         @(posedge clk);
         chan.single_addr <= {4{k[0]}};
         chan.half_word <= {4{k[1]}};
         chan.io_byte <= {4{k[2]}};
         settle;
         check(32'(two_ops), (k == 7) ? 32'h0000_000F : 32'h0000_0000);
      end
   endtask
   initial begin
      rst_n = 1'b0;
      bus = '0;
      chan = '0;
      chan.done_irq_permit = 4'hF;
      trig = '0;
      cpu_ie = 1'b0;
      cpu_il = 3'h0;
      delay = 4'h1;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      t_regs;
      t_done;
      t_arb;
      t_smart(0, 1'b1);
      t_smart(1, 1'b0);
      t_trig;
      t_ops;
      complete_run;
   end
endmodule
